// ### rtl/pdc_defs.svh
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PDC_CMD_OFS 8'h00
`define PDC_OPT_OFS 8'h04
`define PDC_PIC_BASE_OFS 8'h08
`define PDC_PIC_OFFSET_OFS 8'h0C
`define PDC_CHUNK_OFS 8'h10
`define PDC_SEQ_BASE_OFS 8'h14
`define PDC_STATUS_OFS 8'h18
`define PDC_INT_EN_OFS 8'h1C
`define PDC_RESULT_OFS 8'h20

// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define PDC_CMD_RUN_BIT 0

// ----------------------------------------------------------------------
// option register fields
// ----------------------------------------------------------------------
`define PDC_OPT_PRESCAN_EN_BIT 0
`define PDC_OPT_PRESCAN_MODE_BIT 1
`define PDC_OPT_INTRA_SEARCH_BIT 2
`define PDC_OPT_SKIP_MODE_BIT 3
`define PDC_OPT_FLUSH_BIT 4
`define PDC_OPT_PER_PIC_BIT 5
`define PDC_OPT_FILE_PLAY_BIT 6
`define PDC_OPT_REORDER_EN_BIT 7
`define PDC_OPT_SKIP_LSB 8
`define PDC_OPT_SKIP_MSB 15
`define PDC_OPT_DELAY_LSB 16
`define PDC_OPT_DELAY_MSB 20
`define PDC_OPT_WARMUP_ARM_BIT 21
`define PDC_OPT_USED_MSB 21

// ----------------------------------------------------------------------
// status and interrupt enable fields
// ----------------------------------------------------------------------
`define PDC_ST_BUSY_BIT 0
`define PDC_ST_PRESCAN_BIT 1
`define PDC_ST_STARVING_BIT 2
`define PDC_ST_DONE_BIT 3
`define PDC_INT_DONE_BIT 3

// ----------------------------------------------------------------------
// reset values and result codes
// ----------------------------------------------------------------------
`define PDC_OPT_RESET 32'h0000_0000
`define PDC_WORD_RESET 32'h0000_0000
`define PDC_INT_EN_RESET 32'h0000_0000
`define PDC_IDX_RESET 16'hFFFD
`define PDC_IDX_NONE 16'hFFFF
`define PDC_IDX_SKIPPED 16'hFFFE
`define PDC_IDX_NOT_READY 16'hFFFD

`endif

// ### rtl/pdc_pkg.sv
package pdc_pkg;

    typedef enum logic [2:0] {
        PDC_IDLE = 3'b000,
        PDC_SCAN = 3'b001,
        PDC_GO = 3'b010,
        PDC_HDR = 3'b011,
        PDC_BODY = 3'b100,
        PDC_POST = 3'b101
    } pdc_state_e;

    typedef enum logic [1:0] {
        PDC_M_NORMAL = 2'b00,
        PDC_M_SKIP = 2'b01,
        PDC_M_SEARCH = 2'b10,
        PDC_M_FLUSH = 2'b11
    } pdc_mode_e;

    typedef enum logic [1:0] {
        PDC_OP_DECODE = 2'b00,
        PDC_OP_FLUSH = 2'b01
    } pdc_op_e;

endpackage

// ### rtl/pdc_down_counter.sv
`timescale 1ns/10ps

module pdc_down_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic dec,
    output logic [15:0] count,
    output logic is_one
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
        end else if (load) begin
            count <= load_value;
        end else if (dec && count != 16'h0000) begin
            count <= count - 16'h0001;
        end
    end

    assign is_one = (count == 16'h0001);

endmodule

// ### rtl/pdc_picture_decode_control.sv
// Contract
// - pre-scan on and no full picture: end command at once, no decode
// - pre-scan mode 0 with full picture: go straight on to decoding
// - pre-scan mode 1: return at once with presence code, never decode
// - reorder warm-up: first command decodes delay plus one frames
// - flush flag: output one stored picture, no decode, decoded index -1
// - file play: per-picture base if selected, else sequence base
// - file play: stream length is the command's chunk byte count
// - file play: read from selected base plus start offset
// - command only starts decoding; completion shown by busy and irq
// - skip mode set: skip non-intra frames instead of decoding
// - skip count one forces pre-scan; outcome in pre-scan result
// - skip count above one skips several frames per command
// - intra search count N: skip all before (N+1)th intra, decode it
// - intra search forces pre-scan off, ignoring pre-scan settings
// - stream dry during search: flag it; host keeps feeding data
// - search completion only after the intra frame is decoded
// - completion interrupt enabled by bit 3 of interrupt enable
// - no display: -2 after skipping, -3 otherwise, -1 only at end
// - decoded index -1 if no free buffer or nothing decoded
`timescale 1ns/10ps
`include "pdc_defs.svh"

module pdc_picture_decode_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic picture_ready,
    input wire logic stream_empty,
    input wire logic hdr_valid,
    input wire logic hdr_intra,
    input wire logic frame_done,
    input wire logic no_free_slot,
    input wire logic [15:0] frame_display_slot,
    input wire logic [15:0] frame_decoded_slot,
    output logic frame_go,
    output logic [1:0] frame_op,
    output logic frame_decide,
    output logic frame_keep,
    output logic [31:0] read_addr,
    output logic [31:0] read_len,
    output logic busy_indication,
    output logic search_starving,
    output logic done_irq
);

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [31:0] opt;
    logic [31:0] picture_stream_base;
    logic [31:0] picture_start_offset;
    logic [31:0] chunk_byte_count;
    logic [31:0] sequence_stream_base;
    logic [31:0] int_enable;
    logic done_flag;
    logic prescan_result;
    logic warmup_pending;
    logic [15:0] display_slot_index;
    logic [15:0] decoded_slot_index;
    pdc_pkg::pdc_state_e state;
    pdc_pkg::pdc_mode_e mode;
    logic cap_prescan;
    logic cap_prescan_mode;
    logic cap_skip_mode;
    logic [15:0] cap_skip;
    logic [15:0] cap_frames;
    logic cnt_load;
    logic [15:0] cnt_value;
    logic cnt_dec;
    logic [15:0] cnt;
    logic cnt_one;

    wire logic wr_access = psel && penable && pready && pwrite;
    wire logic setup = psel && !penable && !pready;
    wire logic run_req = wr_access && paddr[7:0] == `PDC_CMD_OFS
        && paddr[31:8] == 24'h00_0000 && pwdata[`PDC_CMD_RUN_BIT];
    wire logic accept = run_req && state == pdc_pkg::PDC_IDLE;
    wire logic [7:0] skip_field = opt[`PDC_OPT_SKIP_MSB:`PDC_OPT_SKIP_LSB];
    wire logic [4:0] delay_field = opt[`PDC_OPT_DELAY_MSB:`PDC_OPT_DELAY_LSB];
    wire logic opt_search = opt[`PDC_OPT_INTRA_SEARCH_BIT];
    wire logic opt_skip_one = (skip_field == 8'h01);
    wire logic done_set = (state == pdc_pkg::PDC_POST);
    wire logic done_clr = wr_access && paddr[7:0] == `PDC_STATUS_OFS
        && paddr[31:8] == 24'h00_0000 && pwdata[`PDC_ST_DONE_BIT];

    // ------------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped words
    // ------------------------------------------------------------------
    logic mapped;
    logic [31:0] rd_word;

    always_comb begin
        mapped = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00);
        rd_word = 32'h0000_0000;
        case (paddr[7:0])
            `PDC_CMD_OFS: rd_word = 32'h0000_0000;
            `PDC_OPT_OFS: rd_word = opt;
            `PDC_PIC_BASE_OFS: rd_word = picture_stream_base;
            `PDC_PIC_OFFSET_OFS: rd_word = picture_start_offset;
            `PDC_CHUNK_OFS: rd_word = chunk_byte_count;
            `PDC_SEQ_BASE_OFS: rd_word = sequence_stream_base;
            `PDC_STATUS_OFS: begin
                rd_word[`PDC_ST_BUSY_BIT] = busy_indication;
                rd_word[`PDC_ST_PRESCAN_BIT] = prescan_result;
                rd_word[`PDC_ST_STARVING_BIT] = search_starving;
                rd_word[`PDC_ST_DONE_BIT] = done_flag;
            end
            `PDC_INT_EN_OFS: rd_word = int_enable;
            `PDC_RESULT_OFS: rd_word = {display_slot_index, decoded_slot_index};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && mapped && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // software written registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt <= `PDC_OPT_RESET;
            picture_stream_base <= `PDC_WORD_RESET;
            picture_start_offset <= `PDC_WORD_RESET;
            chunk_byte_count <= `PDC_WORD_RESET;
            sequence_stream_base <= `PDC_WORD_RESET;
            int_enable <= `PDC_INT_EN_RESET;
        end else if (wr_access && paddr[31:8] == 24'h00_0000) begin
            case (paddr[7:0])
                `PDC_OPT_OFS: opt <= {10'h000, pwdata[`PDC_OPT_USED_MSB:0]};
                `PDC_PIC_BASE_OFS: picture_stream_base <= pwdata;
                `PDC_PIC_OFFSET_OFS: picture_start_offset <= pwdata;
                `PDC_CHUNK_OFS: chunk_byte_count <= pwdata;
                `PDC_SEQ_BASE_OFS: sequence_stream_base <= pwdata;
                `PDC_INT_EN_OFS: int_enable <= pwdata;
                default: ;
            endcase
        end
    end

    // warm-up armed by host, consumed by the first non-flush reordering command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warmup_pending <= 1'b0;
        end else if (wr_access && paddr[7:0] == `PDC_OPT_OFS
                && paddr[31:8] == 24'h00_0000
                && pwdata[`PDC_OPT_WARMUP_ARM_BIT]) begin
            warmup_pending <= 1'b1;
        end else if (accept && opt[`PDC_OPT_REORDER_EN_BIT]
                && !opt[`PDC_OPT_FLUSH_BIT]) begin
            warmup_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // command capture
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= pdc_pkg::PDC_M_NORMAL;
            cap_prescan <= 1'b0;
            cap_prescan_mode <= 1'b0;
            cap_skip_mode <= 1'b0;
            cap_skip <= 16'h0000;
            cap_frames <= 16'h0001;
            read_addr <= 32'h0000_0000;
            read_len <= 32'h0000_0000;
        end else if (accept) begin
            if (opt[`PDC_OPT_FLUSH_BIT]) begin
                mode <= pdc_pkg::PDC_M_FLUSH;
            end else if (opt_search) begin
                mode <= pdc_pkg::PDC_M_SEARCH;
            end else if (skip_field != 8'h00) begin
                mode <= pdc_pkg::PDC_M_SKIP;
            end else begin
                mode <= pdc_pkg::PDC_M_NORMAL;
            end
            // search overrides pre-scan; a single skip forces it
            cap_prescan <= !opt_search
                && (opt[`PDC_OPT_PRESCAN_EN_BIT] || opt_skip_one);
            cap_prescan_mode <= opt[`PDC_OPT_PRESCAN_MODE_BIT] && !opt_search;
            cap_skip_mode <= opt[`PDC_OPT_SKIP_MODE_BIT];
            cap_skip <= {8'h00, skip_field};
            cap_frames <= (warmup_pending && opt[`PDC_OPT_REORDER_EN_BIT])
                ? {11'h000, delay_field} + 16'h0001 : 16'h0001;
            if (opt[`PDC_OPT_FILE_PLAY_BIT]) begin
                read_addr <= (opt[`PDC_OPT_PER_PIC_BIT] ? picture_stream_base
                    : sequence_stream_base) + picture_start_offset;
                read_len <= chunk_byte_count;
            end else begin
                read_addr <= sequence_stream_base;
                read_len <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // frame counter: frames to decode, frames to skip or intras to find
    // ------------------------------------------------------------------
    pdc_down_counter u_count (
        .pclk(pclk),
        .presetn(presetn),
        .load(cnt_load),
        .load_value(cnt_value),
        .dec(cnt_dec),
        .count(cnt),
        .is_one(cnt_one)
    );

    wire logic scan_go = state == pdc_pkg::PDC_SCAN
        && mode != pdc_pkg::PDC_M_FLUSH
        && !(cap_prescan && (!picture_ready || cap_prescan_mode));
    wire logic hdr_seen = state == pdc_pkg::PDC_HDR && hdr_valid;
    wire logic skip_drop = mode == pdc_pkg::PDC_M_SKIP
        && !(cap_skip_mode && hdr_intra);
    wire logic search_keep = hdr_intra && cnt_one;
    wire logic keep = (mode == pdc_pkg::PDC_M_SEARCH) ? search_keep
        : !skip_drop;
    wire logic body_more = state == pdc_pkg::PDC_BODY && frame_done
        && mode == pdc_pkg::PDC_M_NORMAL && !cnt_one;

    always_comb begin
        cnt_load = scan_go;
        cnt_value = cap_frames;
        if (mode == pdc_pkg::PDC_M_SEARCH) begin
            cnt_value = cap_skip + 16'h0001;
        end else if (mode == pdc_pkg::PDC_M_SKIP) begin
            cnt_value = cap_skip;
        end
        cnt_dec = body_more
            || (hdr_seen && mode == pdc_pkg::PDC_M_SEARCH && hdr_intra)
            || (hdr_seen && mode == pdc_pkg::PDC_M_SKIP && skip_drop);
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pdc_pkg::PDC_IDLE;
        end else begin
            case (state)
                pdc_pkg::PDC_IDLE: begin
                    if (accept) begin
                        state <= pdc_pkg::PDC_SCAN;
                    end
                end
                pdc_pkg::PDC_SCAN: begin
                    if (mode == pdc_pkg::PDC_M_FLUSH) begin
                        state <= pdc_pkg::PDC_BODY;
                    end else if (scan_go) begin
                        state <= pdc_pkg::PDC_GO;
                    end else begin
                        state <= pdc_pkg::PDC_POST;
                    end
                end
                pdc_pkg::PDC_GO: state <= pdc_pkg::PDC_HDR;
                pdc_pkg::PDC_HDR: begin
                    if (hdr_valid && keep) begin
                        state <= pdc_pkg::PDC_BODY;
                    end else if (hdr_valid && mode == pdc_pkg::PDC_M_SKIP
                            && cnt_one) begin
                        state <= pdc_pkg::PDC_POST;
                    end else if (hdr_valid) begin
                        state <= pdc_pkg::PDC_GO;
                    end
                end
                pdc_pkg::PDC_BODY: begin
                    if (frame_done) begin
                        state <= body_more ? pdc_pkg::PDC_GO
                            : pdc_pkg::PDC_POST;
                    end
                end
                pdc_pkg::PDC_POST: state <= pdc_pkg::PDC_IDLE;
                default: state <= pdc_pkg::PDC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // datapath strobes
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_go <= 1'b0;
            frame_op <= pdc_pkg::PDC_OP_DECODE;
            frame_decide <= 1'b0;
            frame_keep <= 1'b0;
        end else begin
            frame_go <= (state == pdc_pkg::PDC_GO)
                || (state == pdc_pkg::PDC_SCAN
                && mode == pdc_pkg::PDC_M_FLUSH);
            frame_op <= (mode == pdc_pkg::PDC_M_FLUSH)
                ? pdc_pkg::PDC_OP_FLUSH : pdc_pkg::PDC_OP_DECODE;
            frame_decide <= hdr_seen;
            if (hdr_seen) begin
                frame_keep <= keep;
            end
        end
    end

    // ------------------------------------------------------------------
    // results and status
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_slot_index <= `PDC_IDX_RESET;
            decoded_slot_index <= `PDC_IDX_NONE;
            prescan_result <= 1'b0;
        end else if (accept) begin
            display_slot_index <= `PDC_IDX_NOT_READY;
            decoded_slot_index <= `PDC_IDX_NONE;
            prescan_result <= 1'b0;
        end else if (state == pdc_pkg::PDC_SCAN) begin
            prescan_result <= cap_prescan && picture_ready;
        end else if (hdr_seen && mode == pdc_pkg::PDC_M_SKIP && !keep
                && cnt_one) begin
            display_slot_index <= `PDC_IDX_SKIPPED;
            decoded_slot_index <= `PDC_IDX_NONE;
        end else if (state == pdc_pkg::PDC_BODY && frame_done) begin
            display_slot_index <= frame_display_slot;
            decoded_slot_index <= (no_free_slot
                || mode == pdc_pkg::PDC_M_FLUSH)
                ? `PDC_IDX_NONE : frame_decoded_slot;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_indication <= 1'b0;
        end else if (accept) begin
            busy_indication <= 1'b1;
        end else if (done_set) begin
            busy_indication <= 1'b0;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (done_set) begin
            done_flag <= 1'b1;
        end else if (done_clr) begin
            done_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_irq <= 1'b0;
            search_starving <= 1'b0;
        end else begin
            done_irq <= (done_flag || done_set)
                && int_enable[`PDC_INT_DONE_BIT];
            search_starving <= stream_empty && busy_indication
                && mode == pdc_pkg::PDC_M_SEARCH;
        end
    end

endmodule

// ### bench/pdc_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// command sequencing checks
// ----------------------------------------------------------------
module pdc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stream_empty,
    input wire logic hdr_valid,
    input wire logic frame_go,
    input wire logic [1:0] frame_op,
    input wire logic frame_decide,
    input wire logic [31:0] read_addr,
    input wire logic [31:0] read_len,
    input wire logic busy_indication,
    input wire logic search_starving
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    go_in_busy_a: assert property (
        frame_go |-> busy_indication && $past(busy_indication))
        else $error("frame start outside a command");
    go_pulse_a: assert property (frame_go |=> !frame_go)
        else $error("frame start longer than one cycle");
    busy_min_a: assert property (
        $rose(busy_indication) |-> busy_indication[*2])
        else $error("busy dropped too early");
    decide_hdr_a: assert property (hdr_valid |=> frame_decide)
        else $error("no decision after header");
    decide_cause_a: assert property (
        frame_decide |-> $past(hdr_valid))
        else $error("decision without header");
    flush_no_decide_a: assert property (
        frame_go && frame_op == 2'b01 |=> !frame_decide[*4])
        else $error("flush led to a decode decision");
    param_hold_a: assert property (
        busy_indication && $past(busy_indication)
        |-> $stable(read_addr) && $stable(read_len))
        else $error("stream window moved while busy");
    starve_cause_a: assert property (
        search_starving |-> $past(stream_empty) && $past(busy_indication))
        else $error("starving flag without empty stream");
endmodule

bind pdc_picture_decode_control pdc_checker pdc_checker_i (.pclk, .presetn,
    .stream_empty, .hdr_valid, .frame_go, .frame_op, .frame_decide,
    .read_addr, .read_len, .busy_indication, .search_starving);

// ### bench/pdc_datapath_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// frame datapath stand-in with adjustable latency
// ----------------------------------------------------------------
module pdc_datapath_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic busy_indication,
    input wire logic frame_go,
    input wire logic [1:0] frame_op,
    input wire logic frame_decide,
    input wire logic frame_keep,
    input wire logic [3:0] lag,
    input wire logic [7:0] intra_seq,
    input wire logic free_none,
    output logic hdr_valid,
    output logic hdr_intra,
    output logic frame_done,
    output logic no_free_slot,
    output logic [15:0] frame_display_slot,
    output logic [15:0] frame_decoded_slot
);
    logic [4:0] wait_h;
    logic [4:0] wait_d;
    logic [2:0] idx;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_valid <= 1'b0;
            frame_done <= 1'b0;
            wait_h <= 5'h00;
            wait_d <= 5'h00;
            idx <= 3'h0;
        end else begin
            hdr_valid <= (wait_h == 5'h01);
            frame_done <= (wait_d == 5'h01);
            wait_h <= (wait_h != 5'h00) ? wait_h - 5'h01 : 5'h00;
            wait_d <= (wait_d != 5'h00) ? wait_d - 5'h01 : 5'h00;
            if (frame_go && frame_op == 2'b00)
                wait_h <= {1'b0, lag} + 5'h01;
            if ((frame_go && frame_op == 2'b01) || (frame_decide && frame_keep))
                wait_d <= {1'b0, lag} + 5'h01;
            if (wait_h == 5'h01)
                idx <= idx + 3'h1;
            else if (!busy_indication)
                idx <= 3'h0;
        end
    end
    // outside their valid cycle these lines show garbage, not the last value
    assign hdr_intra = hdr_valid ? intra_seq[idx - 3'h1] : ~intra_seq[idx];
    assign no_free_slot = frame_done ? free_none : ~free_none;
    assign frame_display_slot = frame_done ? 16'h0004 : {13'h0000, idx};
    assign frame_decoded_slot = frame_done ? 16'h0007 : ~{13'h0000, idx};
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
`include "pdc_defs.svh"
// ----------------------------------------------------------------
// command scenarios over the register bus
// ----------------------------------------------------------------
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, qerr;
    logic [31:0] paddr, pwdata, prdata, read_addr, read_len, q;
    logic picture_ready, stream_empty, hdr_valid, hdr_intra, frame_done;
    logic no_free_slot, frame_go, frame_decide, frame_keep, free_none;
    logic busy_indication, search_starving, done_irq, seen_starve;
    logic [15:0] frame_display_slot, frame_decoded_slot;
    logic [1:0] frame_op;
    logic [3:0] lag;
    logic [7:0] intra_seq;
    int failures, checks, n_go, n_keep;

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    pdc_picture_decode_control pdc_picture_decode_control_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .picture_ready, .stream_empty,
        .hdr_valid, .hdr_intra, .frame_done, .no_free_slot,
        .frame_display_slot, .frame_decoded_slot, .frame_go, .frame_op,
        .frame_decide, .frame_keep, .read_addr, .read_len,
        .busy_indication, .search_starving, .done_irq);
    pdc_datapath_model pdc_datapath_model_i (
        .pclk, .presetn, .busy_indication, .frame_go, .frame_op,
        .frame_decide, .frame_keep, .lag, .intra_seq, .free_none,
        .hdr_valid, .hdr_intra, .frame_done, .no_free_slot,
        .frame_display_slot, .frame_decoded_slot);

    always @(posedge pclk) begin
        if (frame_go === 1'b1) n_go++;
        if (frame_decide === 1'b1 && frame_keep === 1'b1) n_keep++;
        if (search_starving === 1'b1) seen_starve = 1'b1;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) failures++;
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task start(input logic [31:0] opt);
        apb(1'b1, `PDC_OPT_OFS, opt);
        apb(1'b1, `PDC_STATUS_OFS, 32'h00000008);
        n_go = 0;
        n_keep = 0;
        seen_starve = 1'b0;
        apb(1'b1, `PDC_CMD_OFS, 32'h00000001);
    endtask

    task finish(input int go, input int keep, input logic [31:0] res);
        int k;
        @(posedge pclk);
        for (k = 0; busy_indication !== 1'b0 && k < 300; k++)
            @(posedge pclk);
        if (k == 300) failures++;
        chk(n_go, go);
        chk(n_keep, keep);
        apb(1'b0, `PDC_RESULT_OFS, 32'h0);
        chk(q, res);
    endtask

    task t_regs;
        apb(1'b0, `PDC_RESULT_OFS, 32'h0);
        chk(q, 32'hFFFDFFFF);
        apb(1'b0, `PDC_INT_EN_OFS, 32'h0);
        chk(q, 32'h00000000);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, qerr}, 32'h00000001);
    endtask

    task t_prescan;
        picture_ready <= 1'b0;
        start(32'h00000001);
        finish(0, 0, 32'hFFFDFFFF);
        apb(1'b0, `PDC_STATUS_OFS, 32'h0);
        chk(q & 32'hB, 32'h00000008);
        chk({31'h0, done_irq}, 32'h0);
        picture_ready <= 1'b1;
        start(32'h00000003);
        finish(0, 0, 32'hFFFDFFFF);
        apb(1'b0, `PDC_STATUS_OFS, 32'h0);
        chk(q & 32'hB, 32'h0000000A);
    endtask

    task t_normal;
        apb(1'b1, `PDC_INT_EN_OFS, 32'h00000008);
        lag <= 4'h0;
        start(32'h00000001);
        finish(1, 1, 32'h00040007);
        chk({31'h0, done_irq}, 32'h1);
        lag <= 4'hF;
        start(32'h0);
        apb(1'b1, `PDC_CMD_OFS, 32'h00000001);
        finish(1, 1, 32'h00040007);
    endtask

    task t_modes;
        lag <= 4'h2;
        start(32'h00250080);
        finish(6, 6, 32'h00040007);
        start(32'h00000010);
        finish(1, 0, 32'h0004FFFF);
        free_none <= 1'b1;
        start(32'h0);
        finish(1, 1, 32'h0004FFFF);
        free_none <= 1'b0;
        intra_seq <= 8'h00;
        start(32'h00000200);
        finish(2, 0, 32'hFFFEFFFF);
        intra_seq <= 8'h02;
        start(32'h00000308);
        finish(2, 1, 32'h00040007);
    endtask

    task t_search;
        intra_seq <= 8'h0A;
        picture_ready <= 1'b0;
        stream_empty <= 1'b1;
        start(32'h00000105);
        finish(4, 1, 32'h00040007);
        chk({31'h0, seen_starve}, 32'h1);
        stream_empty <= 1'b0;
        picture_ready <= 1'b1;
    endtask

    task t_file;
        lag <= 4'hF;
        apb(1'b1, `PDC_PIC_BASE_OFS, 32'h10000000);
        apb(1'b1, `PDC_PIC_OFFSET_OFS, 32'h00000024);
        apb(1'b1, `PDC_CHUNK_OFS, 32'h00000200);
        apb(1'b1, `PDC_SEQ_BASE_OFS, 32'h20000000);
        start(32'h00000060);
        apb(1'b1, `PDC_PIC_BASE_OFS, 32'h30000000);
        chk(read_addr, 32'h10000024);
        chk(read_len, 32'h00000200);
        finish(1, 1, 32'h00040007);
    endtask

    task end_of_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #1000000;
        failures++;
        end_of_test;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {picture_ready, stream_empty, free_none} = 3'b100;
        {lag, intra_seq, q, qerr} = '0;
        {failures, checks, n_go, n_keep, seen_starve} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_prescan;
        t_normal;
        t_modes;
        t_search;
        t_file;
        end_of_test;
    end
endmodule
